// [shared/ris_consts.vh]
// constants for the reset initialization sequencer
//
// Contract
// - ref clock: primary in host, pci in agent
// - driven resets held at least 512 periods
// - hard released first, soft 16 periods later
// - capture 3-bit source and divide bit
// - free strap pins within 4 ns of hard
// - redrive strap pins 2 periods after release
// - host sync period from primary clock, doubled when divide bit set
// - reset pins open drain, pull low only
// - allow 100 us for pll lock
// - dll lock within 7680 to 122880 cycles
// - bus clock from primary times pll ratio
`ifndef RIS_CONSTS_VH
`define RIS_CONSTS_VH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define RIS_CLK_MHZ         100
`define RIS_PLL_LOCK_US     100
`define RIS_PLL_LOCK_CYC    17'h2710 // 100 us of 100 MHz clock
`define RIS_DLL_MIN_CYC     17'h1e00
`define RIS_DLL_MAX_CYC     17'h1_e000
`define RIS_LOCK_W          17

// ---------------------------------------------------------------
// durations in sync periods (pci, or primary in host)
// ---------------------------------------------------------------
`define RIS_IN_ASSERT_TICKS 6'h20
`define RIS_OUT_HOLD_TICKS  10'h200
`define RIS_SOFT_LAG_TICKS  10'h010
`define RIS_CFG_GAP_TICKS   2'h2

// ---------------------------------------------------------------
// synchroniser bundle layout
// ---------------------------------------------------------------
`define RIS_SYNC_W          17
`define RIS_SB_PRIM         0
`define RIS_SB_PCI          1
`define RIS_SB_POR          2
`define RIS_SB_HARD         3
`define RIS_SB_SOFT         4
`define RIS_SB_PLL          5
`define RIS_SB_DLL          6
`define RIS_SB_HOST         7
`define RIS_SB_SRC_LO       8
`define RIS_SB_DIV          11
`define RIS_SB_RATIO_LO     12
`define RIS_SB_RATIO_HI     15
`define RIS_SB_SPARE        16

`endif

// [core/ris_sync.v]
// two-flop synchroniser for all pin inputs
`timescale 1ns/1ps
`include "ris_consts.vh"

module ris_sync (
    // clock and control
    input  wire                    mclk_in,
    input  wire                    srst_in,
    input  wire                    ce_in,
    // async levels and their synced copies
    input  wire [`RIS_SYNC_W-1:0]  async_in,
    output wire [`RIS_SYNC_W-1:0]  sync_out
);

    reg [`RIS_SYNC_W-1:0] meta_r;
    reg [`RIS_SYNC_W-1:0] sync_r;

    // first stage feeds only the second stage
    always @(posedge mclk_in) begin
        if (srst_in) begin
            meta_r <= {`RIS_SYNC_W{1'b0}};
            sync_r <= {`RIS_SYNC_W{1'b0}};
        end else if (ce_in) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule

// [core/ris_tick.v]
// reference and sync period tick generator
`timescale 1ns/1ps
`include "ris_consts.vh"

module ris_tick (
    // clock and control
    input  wire  mclk_in,
    input  wire  srst_in,
    input  wire  ce_in,
    // synced clock levels and mode
    input  wire  prim_s_in,
    input  wire  pci_s_in,
    input  wire  host_mode_in,
    input  wire  div_sel_in,
    // one-cycle period marks
    output wire  ref_tick_out,
    output wire  sync_tick_out
);

    reg prim_d_r;
    reg pci_d_r;
    reg half_r;

    wire prim_rise = prim_s_in & ~prim_d_r;
    wire pci_rise  = pci_s_in & ~pci_d_r;

    // edge history of the already synced levels
    always @(posedge mclk_in) begin
        if (srst_in) begin
            prim_d_r <= 1'b0;
            pci_d_r  <= 1'b0;
            half_r   <= 1'b0;
        end else if (ce_in) begin
            prim_d_r <= prim_s_in;
            pci_d_r  <= pci_s_in;
            if (prim_rise)
                half_r <= ~half_r;
        end
    end

    // reference edge chosen by mode
    assign ref_tick_out = host_mode_in ? prim_rise : pci_rise;

    // host: sync period is primary, or every second primary edge
    assign sync_tick_out = host_mode_in ?
                           (prim_rise & (~div_sel_in | half_r)) :
                           pci_rise;

endmodule

// [core/ris_seq.v]
// reset initialization sequencer top level
`timescale 1ns/1ps
`include "ris_consts.vh"

module ris_seq #(
    parameter [`RIS_LOCK_W-1:0] PLL_LOCK_CYC = `RIS_PLL_LOCK_CYC,
    parameter [`RIS_LOCK_W-1:0] DLL_MIN_CYC  = `RIS_DLL_MIN_CYC,
    parameter [`RIS_LOCK_W-1:0] DLL_MAX_CYC  = `RIS_DLL_MAX_CYC
) (
    // clock, reset, enable
    input  wire        mclk_in,
    input  wire        srst_in,
    input  wire        ce_in,
    // reference clocks (pins, sampled)
    input  wire        primary_clock_in,
    input  wire        pci_clock_in,
    input  wire        host_mode_in,
    // board reset inputs (pins, active low)
    input  wire        power_on_reset_n_in,
    input  wire        hard_reset_n_in,
    input  wire        soft_reset_n_in,
    // strap values on the shared config pins
    input  wire [2:0]  reset_source_in,
    input  wire        input_clock_divide_select_in,
    input  wire [3:0]  pll_ratio_in,
    // lock indications
    input  wire        pll_lock_in,
    input  wire        dll_lock_in,
    // functional data for the shared pins
    input  wire [3:0]  cfg_func_in,
    // open-drain reset pins
    output wire        hard_reset_n_out,
    output wire        hard_reset_n_oe_n_out,
    output wire        soft_reset_n_out,
    output wire        soft_reset_n_oe_n_out,
    // shared config pins
    output wire [3:0]  cfg_pin_out,
    output wire        cfg_pin_oe_n_out,
    // captured configuration
    output wire [2:0]  reset_source_out,
    output wire        input_clock_divide_select_out,
    output wire [3:0]  bus_pll_ratio_out,
    // status
    output wire        internal_reset_out,
    output wire        pll_timeout_out,
    output wire        dll_timeout_out,
    output wire        sync_tick_out
);

    // ---------------------------------------------------------------
    // input synchronisation
    // ---------------------------------------------------------------
    wire [`RIS_SYNC_W-1:0] raw_w;
    wire [`RIS_SYNC_W-1:0] syn_w;
    assign raw_w = {1'b0,
                    pll_ratio_in,
                    input_clock_divide_select_in,
                    reset_source_in,
                    host_mode_in,
                    dll_lock_in,
                    pll_lock_in,
                    soft_reset_n_in,
                    hard_reset_n_in,
                    power_on_reset_n_in,
                    pci_clock_in,
                    primary_clock_in};

    ris_sync u_sync (
        .mclk_in  (mclk_in),
        .srst_in  (srst_in),
        .ce_in    (ce_in),
        .async_in (raw_w),
        .sync_out (syn_w)
    );

    wire por_n_s = syn_w[`RIS_SB_POR];
    wire hard_s  = ~syn_w[`RIS_SB_HARD];
    wire soft_s  = ~syn_w[`RIS_SB_SOFT];
    wire pll_s   = syn_w[`RIS_SB_PLL];
    wire dll_s   = syn_w[`RIS_SB_DLL];
    wire host_s  = syn_w[`RIS_SB_HOST];

    // ---------------------------------------------------------------
    // period ticks
    // ---------------------------------------------------------------
    reg  div_r;
    wire sync_tick;

    ris_tick u_tick (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .ce_in         (ce_in),
        .prim_s_in     (syn_w[`RIS_SB_PRIM]),
        .pci_s_in      (syn_w[`RIS_SB_PCI]),
        .host_mode_in  (host_s),
        .div_sel_in    (div_r),
        .ref_tick_out  (),
        .sync_tick_out (sync_tick)
    );

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // assertion filter: counts periods while low, clears when high
    function [5:0] flt_next;
        input [5:0] cnt;
        input       asserted;
        input       tick;
        begin
            if (!asserted)
                flt_next = 6'h00;
            else if (tick && cnt != `RIS_IN_ASSERT_TICKS)
                flt_next = cnt + 6'h01;
            else
                flt_next = cnt;
        end
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    localparam [2:0] ST_POR  = 3'h0;
    localparam [2:0] ST_PLL  = 3'h1;
    localparam [2:0] ST_DLL  = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_HREL = 3'h4;
    localparam [2:0] ST_RUN  = 3'h5;
    localparam [2:0] ST_SOFT = 3'h6;
    reg  [2:0]             state_r;
    reg  [2:0]             state_nxt;
    reg  [9:0]             cnt_r;
    reg  [9:0]             cnt_nxt;
    reg  [`RIS_LOCK_W-1:0] lock_cnt_r;
    reg  [`RIS_LOCK_W-1:0] lock_cnt_nxt;
    reg  [5:0]             hflt_r;
    reg  [5:0]             sflt_r;
    reg  [5:0]             hflt_nxt;
    reg  [5:0]             sflt_nxt;
    reg  [2:0]             src_r;
    reg  [3:0]             ratio_r;
    reg                    hard_drv_r;
    reg                    hard_drv_nxt;
    reg                    soft_drv_r;
    reg                    soft_drv_nxt;
    reg                    int_rst_r;
    reg                    int_rst_nxt;
    reg  [1:0]             gap_r;
    reg  [1:0]             gap_nxt;
    reg                    cfg_oe_n_r;
    reg  [3:0]             cfg_q_r;
    reg                    pll_to_r;
    reg                    dll_to_r;
    wire lock_full = (lock_cnt_r == {`RIS_LOCK_W{1'b1}});

    // ---------------------------------------------------------------
    // sequencing
    // ---------------------------------------------------------------
    // power-on reset overrides every state; locks gate the exit
    always @* begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        lock_cnt_nxt = lock_full ? lock_cnt_r
                                 : lock_cnt_r + {{(`RIS_LOCK_W-1){1'b0}}, 1'b1};
        hard_drv_nxt = hard_drv_r;
        soft_drv_nxt = soft_drv_r;
        int_rst_nxt  = int_rst_r;
        // own pin drive would read back as a request, so mask it
        hflt_nxt = flt_next(hflt_r, hard_s & ~hard_drv_r, sync_tick);
        sflt_nxt = flt_next(sflt_r, soft_s & ~soft_drv_r, sync_tick);
        case (state_r)
            ST_POR: begin
                hard_drv_nxt = 1'b1;
                soft_drv_nxt = 1'b1;
                int_rst_nxt  = 1'b1;
                lock_cnt_nxt = {`RIS_LOCK_W{1'b0}};
                if (por_n_s)
                    state_nxt = ST_PLL;
            end
            ST_PLL: begin
                // stay in reset until lock, whatever the wait
                if (pll_s) begin
                    state_nxt    = ST_DLL;
                    lock_cnt_nxt = {`RIS_LOCK_W{1'b0}};
                end
            end
            ST_DLL: begin
                // a lock before the least time is not trusted
                if (dll_s && lock_cnt_r >= DLL_MIN_CYC) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = 10'h000;
                end
            end
            ST_HOLD: begin
                if (sync_tick)
                    cnt_nxt = cnt_r + 10'h001;
                if (cnt_r == `RIS_OUT_HOLD_TICKS) begin
                    state_nxt    = ST_HREL;
                    hard_drv_nxt = 1'b0;
                    cnt_nxt      = 10'h000;
                end
            end
            ST_HREL: begin
                if (sync_tick)
                    cnt_nxt = cnt_r + 10'h001;
                if (cnt_r == `RIS_SOFT_LAG_TICKS) begin
                    state_nxt    = ST_RUN;
                    soft_drv_nxt = 1'b0;
                    int_rst_nxt  = 1'b0;
                end
            end
            ST_RUN: begin
                // hard request wins over soft in the same cycle
                if (hflt_r == `RIS_IN_ASSERT_TICKS) begin
                    state_nxt    = ST_HOLD;
                    hard_drv_nxt = 1'b1;
                    soft_drv_nxt = 1'b1;
                    int_rst_nxt  = 1'b1;
                    cnt_nxt      = 10'h000;
                end else if (sflt_r == `RIS_IN_ASSERT_TICKS) begin
                    state_nxt    = ST_SOFT;
                    soft_drv_nxt = 1'b1;
                    cnt_nxt      = 10'h000;
                end
            end
            ST_SOFT: begin
                if (sync_tick)
                    cnt_nxt = cnt_r + 10'h001;
                if (hflt_r == `RIS_IN_ASSERT_TICKS) begin
                    state_nxt    = ST_HOLD;
                    hard_drv_nxt = 1'b1;
                    int_rst_nxt  = 1'b1;
                    cnt_nxt      = 10'h000;
                end else if (cnt_r == `RIS_OUT_HOLD_TICKS) begin
                    state_nxt    = ST_RUN;
                    soft_drv_nxt = 1'b0;
                end
            end
            default: state_nxt = ST_POR;
        endcase
        if (!por_n_s) begin
            state_nxt    = ST_POR;
            hard_drv_nxt = 1'b1;
            soft_drv_nxt = 1'b1;
            int_rst_nxt  = 1'b1;
        end
    end

    // strap pin gap: counts sync periods since hard release
    always @* begin
        if (hard_drv_nxt)
            gap_nxt = 2'h0;
        else if (sync_tick && gap_r != `RIS_CFG_GAP_TICKS)
            gap_nxt = gap_r + 2'h1;
        else
            gap_nxt = gap_r;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always @(posedge mclk_in) begin
        if (srst_in) begin
            state_r    <= ST_POR;
            cnt_r      <= 10'h000;
            lock_cnt_r <= {`RIS_LOCK_W{1'b0}};
            hflt_r     <= 6'h00;
            sflt_r     <= 6'h00;
            hard_drv_r <= 1'b1;
            soft_drv_r <= 1'b1;
            int_rst_r  <= 1'b1;
            gap_r      <= 2'h0;
            cfg_oe_n_r <= 1'b1;
            cfg_q_r    <= 4'h0;
        end else if (ce_in) begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            lock_cnt_r <= lock_cnt_nxt;
            hflt_r     <= hflt_nxt;
            sflt_r     <= sflt_nxt;
            hard_drv_r <= hard_drv_nxt;
            soft_drv_r <= soft_drv_nxt;
            int_rst_r  <= int_rst_nxt;
            gap_r      <= gap_nxt;
            cfg_q_r    <= cfg_func_in;
            // same edge as hard drive, well inside 4 ns
            cfg_oe_n_r <= hard_drv_nxt |
                          (gap_nxt != `RIS_CFG_GAP_TICKS);
        end
    end

    // synced straps lag like synced por: last value kept predates release
    always @(posedge mclk_in) begin
        if (srst_in) begin
            src_r   <= 3'h0;
            div_r   <= 1'b0;
            ratio_r <= 4'h0;
        end else if (ce_in && !por_n_s) begin
            src_r   <= syn_w[`RIS_SB_SRC_LO+2:`RIS_SB_SRC_LO];
            div_r   <= syn_w[`RIS_SB_DIV];
            ratio_r <= syn_w[`RIS_SB_RATIO_HI:`RIS_SB_RATIO_LO];
        end
    end

    // lock watchdogs: flags only, the sequence keeps waiting
    always @(posedge mclk_in) begin
        if (srst_in) begin
            pll_to_r <= 1'b0;
            dll_to_r <= 1'b0;
        end else if (ce_in) begin
            if (!por_n_s) begin
                pll_to_r <= 1'b0;
                dll_to_r <= 1'b0;
            end else begin
                if (state_r == ST_PLL && lock_cnt_r >= PLL_LOCK_CYC)
                    pll_to_r <= 1'b1;
                if (state_r == ST_DLL && lock_cnt_r >= DLL_MAX_CYC)
                    dll_to_r <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    // open drain: data is always low, only the enable moves
    assign hard_reset_n_out      = 1'b0;
    assign hard_reset_n_oe_n_out = ~hard_drv_r;
    assign soft_reset_n_out      = 1'b0;
    assign soft_reset_n_oe_n_out = ~soft_drv_r;
    assign cfg_pin_out      = cfg_q_r;
    assign cfg_pin_oe_n_out = cfg_oe_n_r;
    assign reset_source_out              = src_r;
    assign input_clock_divide_select_out = div_r;
    assign bus_pll_ratio_out             = ratio_r;
    assign internal_reset_out = int_rst_r;
    assign pll_timeout_out    = pll_to_r;
    assign dll_timeout_out    = dll_to_r;
    assign sync_tick_out      = sync_tick;

endmodule

// [sim/ris_seq_assertions.sv]
// concurrent checks on the reset sequencer ports
`timescale 1ns/1ps

module ris_chk (
    // clock and reset
    input wire       mclk_in,
    input wire       srst_in,
    // board side levels
    input wire       power_on_reset_n_in,
    input wire       hard_reset_n_in,
    input wire [2:0] reset_source_in,
    input wire       input_clock_divide_select_in,
    input wire [3:0] pll_ratio_in,
    input wire       pll_lock_in,
    input wire       dll_lock_in,
    // device side levels
    input wire       hard_reset_n_out,
    input wire       hard_reset_n_oe_n_out,
    input wire       soft_reset_n_out,
    input wire       soft_reset_n_oe_n_out,
    input wire       cfg_pin_oe_n_out,
    input wire [2:0] reset_source_out,
    input wire       input_clock_divide_select_out,
    input wire [3:0] bus_pll_ratio_out,
    input wire       sync_tick_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    // ------------------------
    // tick counters per phase
    // ------------------------
    logic [11:0] hold_r;
    logic [11:0] lag_r;
    logic [11:0] gap_r;
    logic [11:0] pull_r;
    wire  [7:0]  strap_w = {pll_ratio_in, input_clock_divide_select_in,
                            reset_source_in};
    wire  [7:0]  cap_w   = {bus_pll_ratio_out,
                            input_clock_divide_select_out, reset_source_out};

    // saturate at bit 11 so a long run never wraps back below a bound
    function automatic [11:0] bump(input [11:0] c, input en);
        bump = c + {11'h000, en & sync_tick_out & ~c[11]};
    endfunction

    // count ticks while each phase lasts
    always @(posedge mclk_in) begin
        hold_r <= (srst_in | hard_reset_n_oe_n_out) ? 12'h000
                : bump(hold_r, 1'b1);
        lag_r  <= (~srst_in & hard_reset_n_oe_n_out)
                ? bump(lag_r, 1'b1) : 12'h000;
        gap_r  <= (~srst_in & hard_reset_n_oe_n_out)
                ? bump(gap_r, cfg_pin_oe_n_out) : 12'h000;
        pull_r <= (srst_in | hard_reset_n_in) ? 12'h000
                : bump(pull_r, 1'b1);
    end

    // ------------------------
    // properties
    // ------------------------
    property p_open_drain;
        !hard_reset_n_out && !soft_reset_n_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("reset pin driven high");

    property p_hold;
        $rose(hard_reset_n_oe_n_out) |-> hold_r >= 12'h200;
    endproperty
    a_hold: assert property (p_hold)
        else $error("hard reset held too short");

    property p_lag;
        $rose(soft_reset_n_oe_n_out) |->
            hard_reset_n_oe_n_out && lag_r >= 12'h010;
    endproperty
    a_lag: assert property (p_lag)
        else $error("soft released too early");

    property p_cfg_off;
        !hard_reset_n_oe_n_out |-> cfg_pin_oe_n_out;
    endproperty
    a_cfg_off: assert property (p_cfg_off)
        else $error("config pins driven in hard reset");

    property p_cfg_on;
        $fell(cfg_pin_oe_n_out) |->
            hard_reset_n_oe_n_out && gap_r >= 12'h002;
    endproperty
    a_cfg_on: assert property (p_cfg_on)
        else $error("config pins driven too soon");

    property p_lock;
        $rose(hard_reset_n_oe_n_out) |-> pll_lock_in && dll_lock_in;
    endproperty
    a_lock: assert property (p_lock)
        else $error("reset left before lock");

    property p_pull;
        $fell(hard_reset_n_oe_n_out) && power_on_reset_n_in |->
            pull_r >= 12'h020;
    endproperty
    a_pull: assert property (p_pull)
        else $error("short hard pull accepted");

    property p_cap;
        (!power_on_reset_n_in && $stable(strap_w))[*6] |-> cap_w == strap_w;
    endproperty
    a_cap: assert property (p_cap)
        else $error("straps not captured");
endmodule

bind ris_seq ris_chk ris_chk_inst (.*);

// [sim/ris_board.sv]
// board model: oscillators, reset pulls and strap resistors
`timescale 1ns/1ps

module ris_board #(
    parameter PRIM_HALF = 40,
    parameter PCI_HALF  = 60
) (
    // reset pin pulls of both parties
    input  wire logic       dev_hard_oe_n_in,
    input  wire logic       dev_soft_oe_n_in,
    input  wire logic       brd_hard_in,
    input  wire logic       brd_soft_in,
    // shared config pins
    input  wire logic       dev_cfg_oe_n_in,
    input  wire logic [3:0] dev_cfg_in,
    input  wire logic [3:0] strap_in,
    // resolved levels and reference clocks
    output logic            prim_clk_out,
    output logic            pci_clk_out,
    output wire logic       hard_pin_out,
    output wire logic       soft_pin_out,
    output wire logic [3:0] cfg_level_out
);
    // ------------------------
    // free running oscillators
    // ------------------------
    initial prim_clk_out = 1'b0;
    initial pci_clk_out = 1'b0;
    always #(PRIM_HALF) prim_clk_out = ~prim_clk_out;
    always #(PCI_HALF) pci_clk_out = ~pci_clk_out;

    // wired-and with pull-up; nobody drives the pin high
    assign hard_pin_out = dev_hard_oe_n_in & ~brd_hard_in;
    assign soft_pin_out = dev_soft_oe_n_in & ~brd_soft_in;

    // weak strap resistors lose to the device driver
    assign cfg_level_out = dev_cfg_oe_n_in ? strap_in : dev_cfg_in;
endmodule

// [sim/testbench.sv]
// self-checking bench for the reset sequencer
`timescale 1ns/1ps

`define CHK(nm, e, a) begin \
    checks++; \
    if ((a) !== (e)) begin \
        failures++; \
        $display("FAIL %s exp %0h got %0h", nm, e, a); \
    end \
end

module testbench;
    // ------------------------
    // stimulus and wiring
    // ------------------------
    logic       mclk     = 1'b0;
    logic       srst     = 1'b1;
    logic       por_n    = 1'b0;
    logic       host     = 1'b1;
    logic       brd_hard = 1'b0;
    logic       brd_soft = 1'b0;
    logic       pll_lock = 1'b0;
    logic       dll_lock = 1'b0;
    logic [3:0] strap    = 4'h0;
    logic [3:0] ratio    = 4'h0;
    logic [3:0] func     = 4'h9;
    int         failures = 0;
    int         checks   = 0;
    wire        prim, pci, hard_pin, soft_pin, cfg_oe_n, tick;
    wire        hard_oe_n, soft_oe_n, div_out, int_rst, pll_to, dll_to;
    wire  [3:0] cfg_lvl, cfg_pin, ratio_out;
    wire  [2:0] src_out;
    wire  [2:0] oe = {cfg_oe_n, soft_oe_n, hard_oe_n};

    always #5 mclk = ~mclk;

    ris_board ris_board_inst (
        .dev_hard_oe_n_in (hard_oe_n), .dev_soft_oe_n_in (soft_oe_n),
        .brd_hard_in (brd_hard), .brd_soft_in (brd_soft),
        .dev_cfg_oe_n_in (cfg_oe_n), .dev_cfg_in (cfg_pin),
        .strap_in (strap), .prim_clk_out (prim), .pci_clk_out (pci),
        .hard_pin_out (hard_pin), .soft_pin_out (soft_pin),
        .cfg_level_out (cfg_lvl)
    );

    // short lock budgets keep the run brief
    ris_seq #(
        .PLL_LOCK_CYC (17'h14),
        .DLL_MIN_CYC  (17'h08),
        .DLL_MAX_CYC  (17'h28)
    ) ris_seq_inst (
        .mclk_in (mclk), .srst_in (srst), .ce_in (1'b1),
        .primary_clock_in (prim), .pci_clock_in (pci),
        .host_mode_in (host), .power_on_reset_n_in (por_n),
        .hard_reset_n_in (hard_pin), .soft_reset_n_in (soft_pin),
        .reset_source_in (cfg_lvl[2:0]),
        .input_clock_divide_select_in (cfg_lvl[3]),
        .pll_ratio_in (ratio), .pll_lock_in (pll_lock),
        .dll_lock_in (dll_lock), .cfg_func_in (func),
        .hard_reset_n_out (), .hard_reset_n_oe_n_out (hard_oe_n),
        .soft_reset_n_out (), .soft_reset_n_oe_n_out (soft_oe_n),
        .cfg_pin_out (cfg_pin), .cfg_pin_oe_n_out (cfg_oe_n),
        .reset_source_out (src_out),
        .input_clock_divide_select_out (div_out),
        .bus_pll_ratio_out (ratio_out), .internal_reset_out (int_rst),
        .pll_timeout_out (pll_to), .dll_timeout_out (dll_to),
        .sync_tick_out (tick)
    );

    // ------------------------
    // shared tasks
    // ------------------------
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task results;
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // bounded wait on one enable, counting sync ticks meanwhile
    task automatic wait_oe(input int i, input logic v, input int lim,
                           output int tk);
        int k;
        k = 0;
        tk = 0;
        while (oe[i] !== v && k < lim) begin
            tk += (tick === 1'b1);
            step(1);
            k++;
        end
        if (oe[i] !== v) begin
            failures++;
            $display("FAIL wait_oe%0d exp %b got %b", i, v, oe[i]);
            results();
        end
    endtask

    // release order after hard reset lets go
    task automatic t_tail;
        int a;
        int b;
        `CHK("int_hold", 1'b1, int_rst)
        `CHK("soft_first", 1'b0, soft_oe_n)
        wait_oe(2, 1'b0, 400, a);
        `CHK("cfg_gap", 1'b1, a >= 1 && a <= 2)
        `CHK("cfg_data", func, cfg_pin)
        wait_oe(1, 1'b1, 400, b);
        `CHK("soft_lag", 1'b1, a + b >= 16 && a + b <= 17)
        `CHK("int_rel", 1'b0, int_rst)
    endtask

    // locks held back past both budgets; reset must stay on
    task automatic t_lock;
        step(30);
        `CHK("pll_flag", 1'b1, pll_to)
        `CHK("dll_early", 1'b0, dll_to)
        `CHK("pll_wait", 1'b0, hard_oe_n)
        pll_lock = 1'b1;
        step(60);
        `CHK("dll_flag", 1'b1, dll_to)
        `CHK("dll_wait", 1'b0, hard_oe_n)
        dll_lock = 1'b1;
    endtask

    // power-on cycle with straps, then full exit
    task automatic t_boot(input logic h, input logic [3:0] st,
                          input logic slow);
        int tk;
        por_n = 1'b0;
        host = h;
        strap = st;
        ratio = ~st;
        step(640); // 40 periods of the slowest sync tick (divided primary)
        `CHK("src", st[2:0], src_out)
        `CHK("div", st[3], div_out)
        `CHK("ratio", ~st, ratio_out)
        `CHK("pll_clr", 1'b0, pll_to)
        `CHK("dll_clr", 1'b0, dll_to)
        `CHK("por_hold", 1'b0, hard_oe_n)
        por_n = 1'b1;
        step(4);
        strap = ~st;
        step(20);
        `CHK("src_kept", st[2:0], src_out)
        if (slow)
            t_lock;
        wait_oe(0, 1'b1, 20000, tk);
        t_tail;
    endtask

    // a short pull is ignored, a long one starts the flow
    task automatic t_hard_req;
        int tk;
        brd_hard = 1'b1;
        step(240);
        brd_hard = 1'b0;
        step(40);
        `CHK("short_pull", 1'b1, hard_oe_n)
        brd_hard = 1'b1;
        wait_oe(0, 1'b0, 400, tk);
        `CHK("pull_ticks", 1'b1, tk >= 32 && tk <= 33)
        `CHK("cfg_off", 1'b1, cfg_oe_n)
        `CHK("soft_with", 1'b0, soft_oe_n)
        brd_hard = 1'b0;
        wait_oe(0, 1'b1, 6000, tk);
        `CHK("hard_hold", 1'b1, tk >= 512 && tk <= 513)
        t_tail;
    endtask

    // soft request leaves hard reset and config pins alone
    task automatic t_soft_req;
        int tk;
        brd_soft = 1'b1;
        wait_oe(1, 1'b0, 400, tk);
        `CHK("soft_ticks", 1'b1, tk >= 32 && tk <= 33)
        brd_soft = 1'b0;
        wait_oe(1, 1'b1, 6000, tk);
        `CHK("soft_hold", 1'b1, tk >= 512 && tk <= 513)
        `CHK("hard_idle", 1'b1, hard_oe_n)
        `CHK("cfg_kept", 1'b0, cfg_oe_n)
    endtask

    // cycles between two sync ticks
    task automatic t_spacing(input int exp);
        int k;
        k = 0;
        while (tick !== 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        step(1);
        k = 1;
        while (tick !== 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        `CHK("tick_gap", exp, k)
    endtask

    // ------------------------
    // main sequence
    // ------------------------
    initial begin
        step(3);
        srst = 1'b0;
        t_boot(1'b1, 4'h6, 1'b1);
        t_spacing(8);
        t_hard_req;
        t_soft_req;
        t_boot(1'b1, 4'h9, 1'b0);
        t_spacing(16);
        t_boot(1'b0, 4'h3, 1'b0);
        t_spacing(12);
        results();
    end
endmodule
